//--- eipd_pkg.sv
// package of constants and types for the external request latch and pin control block
// assumes a single 125 MHz oscillator clock and an APB register bus with 32-bit data
package eipd_pkg;

  // ==========================================================================
  // clock and timing
  localparam int unsigned CLK_MHZ                 = 125;
  localparam int unsigned BUS_DIV                 = 2;
  localparam int unsigned BUS_KHZ                 = CLK_MHZ * 1000 / BUS_DIV;
  localparam int unsigned MIN_REQUEST_LOW_TIME_NS = 125;
  localparam int unsigned MIN_REQUEST_LOW_CYC     = (MIN_REQUEST_LOW_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PERIOD_LONG_MS          = 1000;
  localparam int unsigned PERIOD_MID_MS           = 500;
  localparam int unsigned PERIOD_SHORT_MS         = 250;
  localparam int unsigned PERIOD_LONG_CYC         = PERIOD_LONG_MS * BUS_KHZ;
  localparam int unsigned PERIOD_MID_CYC          = PERIOD_MID_MS * BUS_KHZ;
  localparam int unsigned PERIOD_SHORT_CYC        = PERIOD_SHORT_MS * BUS_KHZ;

  // ==========================================================================
  // port widths and register bus
  localparam int unsigned FIRST_W  = 8;
  localparam int unsigned SECOND_W = 8;
  localparam int unsigned THIRD_W  = 4;
  localparam int unsigned APB_AW   = 12;
  localparam int unsigned APB_DW   = 32;

  // ==========================================================================
  // register offsets
  localparam logic [APB_AW-1:0] OFF_FIRST_DATA   = 12'h000;
  localparam logic [APB_AW-1:0] OFF_FIRST_DIR    = 12'h004;
  localparam logic [APB_AW-1:0] OFF_SECOND_DATA  = 12'h008;
  localparam logic [APB_AW-1:0] OFF_SECOND_DIR   = 12'h00C;
  localparam logic [APB_AW-1:0] OFF_THIRD_DATA   = 12'h010;
  localparam logic [APB_AW-1:0] OFF_THIRD_DIR    = 12'h014;
  localparam logic [APB_AW-1:0] OFF_CONTROL      = 12'h018;
  localparam logic [APB_AW-1:0] OFF_INT_STATUS   = 12'h01C;
  localparam logic [APB_AW-1:0] OFF_INT_MASK     = 12'h020;

  // ==========================================================================
  // field positions
  localparam int unsigned NUM_EVENTS     = 3;
  localparam int unsigned EV_EXT_REQ     = 0;
  localparam int unsigned EV_SEQ_START   = 1;
  localparam int unsigned EV_PERIODIC    = 2;
  localparam int unsigned CT_PENDING     = 0;
  localparam int unsigned CT_SINGLE_CHIP = 1;
  localparam int unsigned CT_EDGE_LEVEL  = 2;
  localparam int unsigned CT_STOP_EN     = 3;
  localparam int unsigned CT_WATCHDOG_EN = 4;
  localparam int unsigned CT_PERIOD_SEL  = 5;

  // ==========================================================================
  // reset values
  localparam logic [NUM_EVENTS-1:0] STATUS_RESET = 3'h0;
  localparam logic [NUM_EVENTS-1:0] MASK_RESET   = 3'h0;
  localparam logic [APB_DW-1:0]     PRDATA_RESET = 32'h0000_0000;

  // ==========================================================================
  // types
  typedef enum logic {PH_CAPTURE, PH_RUN} eipd_phase_type;

endpackage : eipd_pkg

//--- eipd_low_filter.sv
// qualifies a low level on the request pin once it has lasted the minimum low time
// assumes the pin is already synchronous to clk
`timescale 1ns/100ps

module eipd_low_filter #(
  parameter int unsigned LIMIT = eipd_pkg::MIN_REQUEST_LOW_CYC
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic pin_n,
  output logic      qual_low
);
  import eipd_pkg::*;

  localparam int unsigned CW = $clog2(LIMIT + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          qual;
  } eipd_filt_state_type;

  eipd_filt_state_type q;
  eipd_filt_state_type d;

  // ==========================================================================
  // low-time counter; a high sample restarts it so glitches never qualify
  always_comb
  begin
    d = q;
    if (pin_n)
    begin
      d.cnt  = '0;
      d.qual = 1'b0;
    end
    else if (q.cnt < CW'(LIMIT))
    begin
      d.cnt  = q.cnt + CW'(1);
      d.qual = (q.cnt == CW'(LIMIT - 1));
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      q <= '0;
    else
      q <= d;
  end

  assign qual_low = q.qual;

endmodule : eipd_low_filter

//--- eipd_port.sv
// one bank of bidirectional lines with a data latch and a direction register
// assumes write strobes arrive from the bus slave one cycle wide
`timescale 1ns/100ps

module eipd_port #(
  parameter int unsigned W = 8
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         wr_data,
  input  wire logic         wr_dir,
  input  wire logic [W-1:0] wdata,
  input  wire logic [W-1:0] pad_in,
  output logic      [W-1:0] pad_out,
  output logic      [W-1:0] pad_oe_n,
  output logic      [W-1:0] rd_data,
  output logic      [W-1:0] rd_dir
);
  import eipd_pkg::*;

  typedef struct packed {
    logic [W-1:0] data;
    logic [W-1:0] dir;
  } eipd_port_state_type;

  eipd_port_state_type q;
  eipd_port_state_type d;

  // ==========================================================================
  // latches; the data latch loads even on input lines so a later turn-around drives a known value
  always_comb
  begin
    d = q;
    if (wr_data)
      d.data = wdata;
    if (wr_dir)
      d.dir = wdata;
  end

  // every line is an input out of reset, direction register all zero
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      q <= '0;
    else
      q <= d;
  end

  // output lines read back the latch, input lines read the pin
  assign pad_out  = q.data;
  assign pad_oe_n = ~q.dir;
  assign rd_data  = (q.dir & q.data) | (~q.dir & pad_in);
  assign rd_dir   = q.dir;

endmodule : eipd_port

//--- eipd_pin_ctrl.sv
// pin-level control: external request latch, instruction-boundary test, ports, build options
// assumes one 125 MHz oscillator clock, an APB master, and a cpu that flags instruction ends
//
// Contract
// - The request input is built either for falling edges only or for falling edges plus held low level.
// - A request held low for the minimum low time sets the pending-request latch.
// - A pending request is answered only once the current instruction has finished.
// - At each instruction end in a bus cycle the latch is tested and the sequence starts when it is set and the mask is clear.
// - The eight first port lines are programmable and are all inputs after every reset.
// - The eight second port lines are programmable and are all inputs after every reset.
// - The four third port lines are programmable and are all inputs after every reset.
// - Without the frequency synthesizer the bus clock runs at half the oscillator rate.
// - Holding reset low returns the whole block to a defined start-up state.
// - Stop enable, watchdog enable and a periodic interval of one, one half or one quarter second are build options.
// - Normal single-chip operation is chosen at reset release when the request pin is in its normal range.
`timescale 1ns/100ps

module eipd_pin_ctrl #(
  parameter bit          EDGE_AND_LEVEL   = 1'b0,
  parameter bit          STOP_ENABLE      = 1'b1,
  parameter bit          WATCHDOG_ENABLE  = 1'b0,
  parameter logic [1:0]  PERIOD_SEL       = 2'h0,
  parameter int unsigned PERIOD_LONG_CYC  = eipd_pkg::PERIOD_LONG_CYC,
  parameter int unsigned PERIOD_MID_CYC   = eipd_pkg::PERIOD_MID_CYC,
  parameter int unsigned PERIOD_SHORT_CYC = eipd_pkg::PERIOD_SHORT_CYC
) (
  input  wire logic                           clk,
  input  wire logic                           reset_n,
  // apb slave
  input  wire logic [eipd_pkg::APB_AW-1:0]    paddr,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [eipd_pkg::APB_DW-1:0]    pwdata,
  output logic      [eipd_pkg::APB_DW-1:0]    prdata,
  output logic                                pready,
  output logic                                pslverr,
  // request pin and cpu side
  input  wire logic                           request_n,
  input  wire logic                           request_test_level,
  input  wire logic                           instr_done,
  input  wire logic                           cpu_i_mask,
  output logic                                bus_clk_en,
  output logic                                irq_seq_start,
  output logic                                single_chip,
  output logic                                stop_allowed,
  output logic                                watchdog_option,
  output logic                                periodic_interrupt,
  output logic                                irq,
  // port pins
  input  wire logic [eipd_pkg::FIRST_W-1:0]   first_port_lines_in,
  output logic      [eipd_pkg::FIRST_W-1:0]   first_port_lines_out,
  output logic      [eipd_pkg::FIRST_W-1:0]   first_port_lines_oe_n,
  input  wire logic [eipd_pkg::SECOND_W-1:0]  second_port_lines_in,
  output logic      [eipd_pkg::SECOND_W-1:0]  second_port_lines_out,
  output logic      [eipd_pkg::SECOND_W-1:0]  second_port_lines_oe_n,
  input  wire logic [eipd_pkg::THIRD_W-1:0]   third_port_lines_in,
  output logic      [eipd_pkg::THIRD_W-1:0]   third_port_lines_out,
  output logic      [eipd_pkg::THIRD_W-1:0]   third_port_lines_oe_n
);
  import eipd_pkg::*;

  // ==========================================================================
  // build options
  localparam int unsigned PER_LIMIT = (PERIOD_SEL == 2'h0) ? PERIOD_LONG_CYC :
                                      (PERIOD_SEL == 2'h1) ? PERIOD_MID_CYC : PERIOD_SHORT_CYC;
  localparam int unsigned PER_W     = $clog2(PERIOD_LONG_CYC + 1);

  typedef struct packed {
    eipd_phase_type        phase;
    logic                  bus_ph;
    logic                  single_chip;
    logic                  qual_prev;
    logic                  pending;
    logic                  seq_start;
    logic                  per_tick;
    logic [PER_W-1:0]      per_cnt;
    logic [NUM_EVENTS-1:0] status;
    logic [NUM_EVENTS-1:0] mask;
    logic                  irq_line;
    logic [APB_DW-1:0]     prdata;
    logic                  pslverr;
  } eipd_top_state_type;

  eipd_top_state_type q;
  eipd_top_state_type d;

  logic                  qual_low;
  logic                  bus_en;
  logic                  setup;
  logic                  access;
  logic                  hit;
  logic [APB_DW-1:0]     rdata;
  logic                  req_set;
  logic                  take;
  logic [NUM_EVENTS-1:0] events;
  logic                  wr_first_data;
  logic                  wr_first_dir;
  logic                  wr_second_data;
  logic                  wr_second_dir;
  logic                  wr_third_data;
  logic                  wr_third_dir;
  logic [FIRST_W-1:0]    first_rd;
  logic [FIRST_W-1:0]    first_dir;
  logic [SECOND_W-1:0]   second_rd;
  logic [SECOND_W-1:0]   second_dir;
  logic [THIRD_W-1:0]    third_rd;
  logic [THIRD_W-1:0]    third_dir;
  logic [APB_DW-1:0]     control_val;

  // ==========================================================================
  // request qualification and the three port banks
  eipd_low_filter #(
    .LIMIT    (MIN_REQUEST_LOW_CYC)
  ) u_filter (
    .clk      (clk),
    .reset_n  (reset_n),
    .pin_n    (request_n),
    .qual_low (qual_low)
  );

  eipd_port #(
    .W        (FIRST_W)
  ) u_first (
    .clk      (clk),
    .reset_n  (reset_n),
    .wr_data  (wr_first_data),
    .wr_dir   (wr_first_dir),
    .wdata    (pwdata[FIRST_W-1:0]),
    .pad_in   (first_port_lines_in),
    .pad_out  (first_port_lines_out),
    .pad_oe_n (first_port_lines_oe_n),
    .rd_data  (first_rd),
    .rd_dir   (first_dir)
  );

  eipd_port #(
    .W        (SECOND_W)
  ) u_second (
    .clk      (clk),
    .reset_n  (reset_n),
    .wr_data  (wr_second_data),
    .wr_dir   (wr_second_dir),
    .wdata    (pwdata[SECOND_W-1:0]),
    .pad_in   (second_port_lines_in),
    .pad_out  (second_port_lines_out),
    .pad_oe_n (second_port_lines_oe_n),
    .rd_data  (second_rd),
    .rd_dir   (second_dir)
  );

  eipd_port #(
    .W        (THIRD_W)
  ) u_third (
    .clk      (clk),
    .reset_n  (reset_n),
    .wr_data  (wr_third_data),
    .wr_dir   (wr_third_dir),
    .wdata    (pwdata[THIRD_W-1:0]),
    .pad_in   (third_port_lines_in),
    .pad_out  (third_port_lines_out),
    .pad_oe_n (third_port_lines_oe_n),
    .rd_data  (third_rd),
    .rd_dir   (third_dir)
  );

  // ==========================================================================
  // bus decode; writes land at the access edge, reads are captured at setup
  assign bus_en = q.bus_ph;
  assign setup  = psel & ~penable;
  assign access = psel & penable;

  assign wr_first_data  = access & pwrite & (paddr == OFF_FIRST_DATA);
  assign wr_first_dir   = access & pwrite & (paddr == OFF_FIRST_DIR);
  assign wr_second_data = access & pwrite & (paddr == OFF_SECOND_DATA);
  assign wr_second_dir  = access & pwrite & (paddr == OFF_SECOND_DIR);
  assign wr_third_data  = access & pwrite & (paddr == OFF_THIRD_DATA);
  assign wr_third_dir   = access & pwrite & (paddr == OFF_THIRD_DIR);

  // build options read back so software can tell which variant it runs on
  always_comb
  begin
    control_val                 = '0;
    control_val[CT_PENDING]     = q.pending;
    control_val[CT_SINGLE_CHIP] = q.single_chip;
    control_val[CT_EDGE_LEVEL]  = EDGE_AND_LEVEL;
    control_val[CT_STOP_EN]     = STOP_ENABLE;
    control_val[CT_WATCHDOG_EN] = WATCHDOG_ENABLE;
    control_val[CT_PERIOD_SEL +: 2] = PERIOD_SEL;
  end

  // read mux; an unmapped offset answers with an error and zero data
  always_comb
  begin
    hit   = 1'b1;
    rdata = '0;
    case (paddr)
      OFF_FIRST_DATA  : rdata = APB_DW'(first_rd);
      OFF_FIRST_DIR   : rdata = APB_DW'(first_dir);
      OFF_SECOND_DATA : rdata = APB_DW'(second_rd);
      OFF_SECOND_DIR  : rdata = APB_DW'(second_dir);
      OFF_THIRD_DATA  : rdata = APB_DW'(third_rd);
      OFF_THIRD_DIR   : rdata = APB_DW'(third_dir);
      OFF_CONTROL     : rdata = control_val;
      OFF_INT_STATUS  : rdata = APB_DW'(q.status);
      OFF_INT_MASK    : rdata = APB_DW'(q.mask);
      default         : hit   = 1'b0;
    endcase
  end

  // ==========================================================================
  // request latch: edge always sets, the level build also sets while held low
  assign req_set = (qual_low & ~q.qual_prev) | (EDGE_AND_LEVEL & qual_low);

  // only an instruction end on a bus cycle may start the sequence
  assign take = (q.phase == PH_RUN) & bus_en & instr_done & q.pending & ~cpu_i_mask;

  assign events[EV_EXT_REQ]   = req_set & ~q.pending;
  assign events[EV_SEQ_START] = take;
  assign events[EV_PERIODIC]  = q.per_tick;

  // ==========================================================================
  // next state
  always_comb
  begin
    d           = q;
    d.bus_ph    = ~q.bus_ph;
    d.qual_prev = qual_low;
    d.seq_start = take;
    d.per_tick  = 1'b0;
    // capture the operating mode once, right after reset release
    case (q.phase)
      PH_CAPTURE :
      begin
        d.single_chip = ~request_test_level;
        d.phase       = PH_RUN;
      end
      PH_RUN :
      begin
        d.phase = PH_RUN;
      end
      default :
      begin
        d.phase = PH_CAPTURE;
      end
    endcase
    // set wins over the clear of a taken sequence, so a level still low re-arms
    d.pending = (q.phase == PH_RUN) & (req_set | (q.pending & ~take));
    // periodic interval counted on bus cycles
    if (bus_en)
    begin
      if (q.per_cnt == PER_W'(PER_LIMIT - 1))
      begin
        d.per_cnt  = '0;
        d.per_tick = 1'b1;
      end
      else
        d.per_cnt = q.per_cnt + PER_W'(1);
    end
    // reading status clears only the bits that were handed out, events win
    if (access & ~pwrite & (paddr == OFF_INT_STATUS))
      d.status = (q.status & ~q.prdata[NUM_EVENTS-1:0]) | events;
    else
      d.status = q.status | events;
    if (access & pwrite & (paddr == OFF_INT_MASK))
      d.mask = pwdata[NUM_EVENTS-1:0];
    d.irq_line = |(d.status & d.mask);
    // read data and error are loaded in the setup cycle and held through access
    if (setup)
    begin
      d.prdata  = rdata;
      d.pslverr = ~hit;
    end
  end

  // ==========================================================================
  // state register; reset puts every field at its start-up value
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q             <= '0;
      q.phase       <= PH_CAPTURE;
      q.single_chip <= 1'b1;
      q.status      <= STATUS_RESET;
      q.mask        <= MASK_RESET;
      q.prdata      <= PRDATA_RESET;
    end
    else
      q <= d;
  end

  // ==========================================================================
  // outputs
  assign prdata             = q.prdata;
  assign pslverr            = q.pslverr;
  assign pready             = 1'b1;
  assign bus_clk_en         = q.bus_ph;
  assign irq_seq_start      = q.seq_start;
  assign single_chip        = q.single_chip;
  assign stop_allowed       = STOP_ENABLE;
  assign watchdog_option    = WATCHDOG_ENABLE;
  assign periodic_interrupt = q.per_tick;
  assign irq                = q.irq_line;

  // ==========================================================================
  // checks
  chk_start_needs_pending : assert property (@(posedge clk) disable iff (!reset_n)
    irq_seq_start |-> $past(q.pending) && !$past(cpu_i_mask))
    else $error("sequence started without a pending unmasked request");

  chk_start_at_boundary : assert property (@(posedge clk) disable iff (!reset_n)
    irq_seq_start |-> $past(instr_done) && $past(bus_en))
    else $error("sequence started outside an instruction end");

  chk_low_sets_latch : assert property (@(posedge clk) disable iff (!reset_n)
    (q.phase == PH_RUN) && $rose(qual_low) |=> q.pending)
    else $error("qualified low request did not set the latch");

  chk_filter_min_low : assert property (@(posedge clk) disable iff (!reset_n)
    $rose(qual_low) |-> !$past(request_n, 1) && !$past(request_n, 2))
    else $error("request qualified before the minimum low time");

  chk_latch_rearm : assert property (@(posedge clk) disable iff (!reset_n)
    take && !req_set |=> !q.pending)
    else $error("latch not cleared when the sequence was taken");

  chk_level_rearm : assert property (@(posedge clk) disable iff (!reset_n)
    EDGE_AND_LEVEL && take && qual_low |=> q.pending)
    else $error("level build did not re-arm while request held low");

  chk_bus_half_rate : assert property (@(posedge clk) disable iff (!reset_n)
    bus_clk_en |=> !bus_clk_en ##1 bus_clk_en)
    else $error("bus enable not at half the oscillator rate");

  chk_first_inputs : assert property (@(posedge clk) disable iff (!reset_n)
    q.phase == PH_CAPTURE |-> &first_port_lines_oe_n)
    else $error("first port drives after reset");

  chk_second_inputs : assert property (@(posedge clk) disable iff (!reset_n)
    q.phase == PH_CAPTURE |-> &second_port_lines_oe_n)
    else $error("second port drives after reset");

  chk_third_inputs : assert property (@(posedge clk) disable iff (!reset_n)
    q.phase == PH_CAPTURE |-> &third_port_lines_oe_n)
    else $error("third port drives after reset");

  chk_mode_capture : assert property (@(posedge clk) disable iff (!reset_n)
    q.phase == PH_CAPTURE |=> single_chip == !$past(request_test_level) && q.phase == PH_RUN)
    else $error("operating mode not captured at reset release");

  chk_start_state : assert property (@(posedge clk) disable iff (!reset_n)
    $rose(reset_n) |-> !q.pending && q.status == STATUS_RESET && !irq)
    else $error("block not in start-up state after reset");

  chk_period_gap : assert property (@(posedge clk) disable iff (!reset_n)
    periodic_interrupt |=> !periodic_interrupt [*8])
    else $error("periodic ticks too close together");

endmodule : eipd_pin_ctrl

//--- eipd_req_model.sv
// model of the outside logic that drives the request pin
// assumes a pull-up on the line, so a released pin reads high
`timescale 1ns/100ps

module eipd_req_model (
  input  wire logic clk,
  output logic      request_n
);
  // ==========================================================================
  // request line
  initial request_n = 1'b1;

  // hold the line low for n clocks, then let the pull-up take it high
  task automatic low(input int n);
    @(posedge clk);
    request_n <= 1'b0;
    repeat (n) @(posedge clk);
    request_n <= 1'b1;
  endtask : low
endmodule : eipd_req_model

//--- tb.sv
// self-checking bench for the request latch and pin control block
// assumes the design package is compiled first; clk is 125 MHz
`timescale 1ns/100ps

module tb;
  import eipd_pkg::*;
  logic        clk, reset_n, psel, penable, pwrite, tlvl, idone, imask;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic        pready, pslverr, rerr, req_n, bce, seq, chip, stp, wdg, tick, irq;
  logic        seq2, tick2;
  logic [7:0]  a_in, a_out, a_oe, b_in, b_out, b_oe;
  logic [3:0]  c_in, c_out, c_oe;
  logic [31:0] exp_d [3] = '{32'h53, 32'hA3, 32'h3};
  int          miscompares, compares, cycles, n;

  eipd_req_model REQ (.clk(clk), .request_n(req_n));

  // short periodic counts keep the run brief
  eipd_pin_ctrl #(.PERIOD_LONG_CYC(40), .PERIOD_MID_CYC(20), .PERIOD_SHORT_CYC(10)) DUT (
    .clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .request_n(req_n), .request_test_level(tlvl), .instr_done(idone), .cpu_i_mask(imask),
    .bus_clk_en(bce), .irq_seq_start(seq), .single_chip(chip), .stop_allowed(stp),
    .watchdog_option(wdg), .periodic_interrupt(tick), .irq(irq),
    .first_port_lines_in(a_in), .first_port_lines_out(a_out), .first_port_lines_oe_n(a_oe),
    .second_port_lines_in(b_in), .second_port_lines_out(b_out), .second_port_lines_oe_n(b_oe),
    .third_port_lines_in(c_in), .third_port_lines_out(c_out), .third_port_lines_oe_n(c_oe));

  // level-sensitive build with the short interval, fed from the same pins and bus
  eipd_pin_ctrl #(.EDGE_AND_LEVEL(1'b1), .PERIOD_SEL(2'h2), .PERIOD_LONG_CYC(40), .PERIOD_MID_CYC(20),
    .PERIOD_SHORT_CYC(10)) DUT_LVL (
    .clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .request_n(req_n), .request_test_level(tlvl), .instr_done(idone), .cpu_i_mask(imask),
    .bus_clk_en(), .irq_seq_start(seq2), .single_chip(), .stop_allowed(),
    .watchdog_option(), .periodic_interrupt(tick2), .irq(),
    .first_port_lines_in(a_in), .first_port_lines_out(), .first_port_lines_oe_n(),
    .second_port_lines_in(b_in), .second_port_lines_out(), .second_port_lines_oe_n(),
    .third_port_lines_in(c_in), .third_port_lines_out(), .third_port_lines_oe_n());

  // ==========================================================================
  // clock and hang guard
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // a hang counts as a mismatch and closes the run
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      finish_test();
    end
  end

  // ==========================================================================
  // tasks
  task automatic finish_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // one apb transfer; holds the request until pready is seen high
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // flag an instruction end in a bus-rate cycle, then look one cycle later
  task automatic instr;
    @(negedge clk);
    while (bce !== 1'b1) @(negedge clk);
    repeat (2) @(posedge clk);
    idone <= 1'b1;
    @(posedge clk);
    idone <= 1'b0;
    @(negedge clk);
  endtask : instr

  // release just after an edge, a full cycle clear of the next, since there is no reset synchroniser
  task automatic rst(input logic lvl);
    @(posedge clk);
    tlvl    <= lvl;
    reset_n <= 1'b0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    cmp({a_oe, b_oe, c_oe}, 20'hF_FFFF);
    cmp({a_out, b_out, c_out}, 20'h0_0000);
    // one more edge so the mode captured at release is visible
    @(negedge clk);
  endtask : rst

  // ==========================================================================
  // main sequence
  initial
  begin
    {reset_n, psel, penable, pwrite, tlvl, idone, imask} = 7'h0;
    {paddr, pwdata} = 44'h0;
    {a_in, b_in, c_in} = 20'h5A_A56;
    rst(1'b0);
    cmp(chip, 1'b1);
    cmp({stp, wdg}, 2'b10);
    while (bce !== 1'b1) @(negedge clk);
    @(negedge clk);
    cmp(bce, 1'b0);
    @(negedge clk);
    cmp(bce, 1'b1);
    apb(OFF_CONTROL, 1'b0, 32'h0);
    cmp(rdata, 32'h0000_000A);
    apb(12'h040, 1'b0, 32'h0);
    cmp({rerr, rdata[30:0]}, 32'h8000_0000);
    // first and second ports: low nibble driven, high nibble read from the pins; all four third port lines driven
    for (int i = 0; i < 3; i++)
    begin
      apb(12'(8 * i + 4), 1'b1, 32'h0F);
      apb(12'(8 * i), 1'b1, 32'hC3);
      apb(12'(8 * i), 1'b0, 32'h0);
      cmp(rdata, exp_d[i]);
    end
    cmp({a_oe, b_oe, c_oe, a_out[3:0]}, 24'hF0F0_03);
    apb(OFF_INT_MASK, 1'b1, 32'h3);
    apb(OFF_INT_STATUS, 1'b0, 32'h0);
    REQ.low(15);
    apb(OFF_CONTROL, 1'b0, 32'h0);
    cmp({irq, rdata[0]}, 2'b00);
    REQ.low(16);
    apb(OFF_CONTROL, 1'b0, 32'h0);
    cmp({irq, rdata[0]}, 2'b11);
    apb(OFF_INT_STATUS, 1'b0, 32'h0);
    cmp(rdata & 32'h3, 32'h1);
    repeat (2) @(negedge clk);
    cmp(irq, 1'b0);
    @(posedge clk);
    imask <= 1'b1;
    instr;
    cmp(seq, 1'b0);
    @(posedge clk);
    imask <= 1'b0;
    instr;
    cmp(seq, 1'b1);
    cmp(seq2, 1'b1);
    cmp(irq, 1'b1);
    apb(OFF_CONTROL, 1'b0, 32'h0);
    cmp(rdata[0], 1'b0);
    // interval of the periodic tick at the long setting, in clocks
    while (tick !== 1'b1) @(negedge clk);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (tick !== 1'b1);
    cmp(n, 80);
    // short setting on the level build: ten bus cycles
    while (tick2 !== 1'b1) @(negedge clk);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (tick2 !== 1'b1);
    cmp(n, 20);
    // request held low across two instruction ends: only the level build answers twice
    fork
      REQ.low(60);
      begin
        repeat (20) @(posedge clk);
        instr;
        cmp({seq, seq2}, 2'b11);
        instr;
        cmp({seq, seq2}, 2'b01);
      end
    join
    rst(1'b1);
    cmp(chip, 1'b0);
    finish_test();
  end
endmodule : tb
